// ### core/ctc_core.sv
// Behaviour
// - continuous results spaced from one ready falling edge to the next
// - first conversion starts 28.5 periods (normal) or 105 (turbo) after start
// - start latency added only before the first conversion after start
// - single-shot time runs from start latch to ready falling edge
// - continuous periods 51192 down to 1036 oscillator periods per rate
// - single-shot times per rate, separate normal and turbo tables
// - oscillator period is 1.024 MHz normal, 2.048 MHz turbo
// - every delivered result is settled; none discarded
// - three-bit current code selects source current, 000 is off
// - each source has its own three-bit routing field
// - allow 200 us start-up after a nonzero current code is programmed
// - single-shot keeps sources powered between conversions when code nonzero
// - sleep command powers sources down regardless of code
// - bias enabled whenever code nonzero and not asleep, even with no pin routed
// - current reaches a pin only while its routing field is nonzero
// - modulator tick at one quarter of the oscillator frequency
`timescale 1ns/1ns
`include "ctc_map.svh"
module ctc_core (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write
  input  wire logic [`CTC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [`CTC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // filter result
  input  wire logic [23:0]            filter_data,
  // converter
  output logic                        result_ready_n,
  output logic                        mod_tick,
  // excitation
  output logic                        exc_bias_en,
  output logic [2:0]                  excitation_current_code,
  output logic [2:0]                  first_source_route,
  output logic [2:0]                  second_source_route,
  output logic                        first_source_drive,
  output logic                        second_source_drive,
  output logic                        exc_current_valid
);

  localparam logic [63:0] INC_N64 =
    ((64'(2 * `CTC_OSC_NORM_KHZ) << `CTC_ACC_BITS) + 64'(`CTC_CLK_KHZ / 2))
    / 64'(`CTC_CLK_KHZ);
  localparam logic [63:0] INC_T64 =
    ((64'(2 * `CTC_OSC_TURBO_KHZ) << `CTC_ACC_BITS) + 64'(`CTC_CLK_KHZ / 2))
    / 64'(`CTC_CLK_KHZ);
  localparam logic [`CTC_ACC_BITS-1:0] INC_NORM  = INC_N64[`CTC_ACC_BITS-1:0];
  localparam logic [`CTC_ACC_BITS-1:0] INC_TURBO = INC_T64[`CTC_ACC_BITS-1:0];
  localparam logic [11:0] EXC_START_CYC =
    12'((`CTC_EXC_START_US * `CTC_CLK_KHZ + 999) / 1000);

  function automatic logic [15:0] ctc_time(input logic [2:0] r, input logic ss,
                                           input logic tb);
    logic [15:0] c;
    logic [15:0] n;
    logic [15:0] t;
    unique case (r)
      3'h0: begin c = `CTC_CONT_0; n = `CTC_SSN_0; t = `CTC_SST_0; end
      3'h1: begin c = `CTC_CONT_1; n = `CTC_SSN_1; t = `CTC_SST_1; end
      3'h2: begin c = `CTC_CONT_2; n = `CTC_SSN_2; t = `CTC_SST_2; end
      3'h3: begin c = `CTC_CONT_3; n = `CTC_SSN_3; t = `CTC_SST_3; end
      3'h4: begin c = `CTC_CONT_4; n = `CTC_SSN_4; t = `CTC_SST_4; end
      3'h5: begin c = `CTC_CONT_5; n = `CTC_SSN_5; t = `CTC_SST_5; end
      default: begin c = `CTC_CONT_6; n = `CTC_SSN_6; t = `CTC_SST_6; end
    endcase
    return ss ? (tb ? t : n) : c;
  endfunction

  // bus registers
  logic                    aw_got_reg, aw_got_next;
  logic                    w_got_reg, w_got_next;
  logic [`CTC_ADDR_W-1:0]  awaddr_reg, awaddr_next;
  logic [31:0]             wdata_reg, wdata_next;
  logic [3:0]              wstrb_reg, wstrb_next;
  logic                    bvalid_reg, bvalid_next;
  logic [1:0]              bresp_reg, bresp_next;
  logic                    rvalid_reg, rvalid_next;
  logic [1:0]              rresp_reg, rresp_next;
  logic [31:0]             rdata_reg, rdata_next;
  logic                    wr_fire, rd_fire, start_cmd, sleep_cmd, result_read;
  // converter and excitation state
  ctc_pkg::ctc_ctrl_type   ctrl_reg, ctrl_next;
  ctc_pkg::ctc_ctrl_type   run_reg, run_next;
  ctc_pkg::ctc_exc_type    exc_reg, exc_next;
  ctc_pkg::ctc_state_type  state_reg, state_next;
  logic [`CTC_ACC_BITS-1:0] acc_reg, acc_next;
  logic                    half_tick_reg, half_tick_next;
  logic [2:0]              mod_cnt_reg, mod_cnt_next;
  logic                    mod_tick_reg, mod_tick_next;
  logic                    ready_n_reg, ready_n_next;
  logic [23:0]             result_reg, result_next;
  logic                    asleep_reg, asleep_next;
  logic                    bias_reg, bias_next;
  logic                    drv1_reg, drv1_next;
  logic                    drv2_reg, drv2_next;
  logic                    valid_reg, valid_next;
  logic                    conv_load, conv_done, conv_last, exc_load, exc_done;
  logic [16:0]             conv_val, conv_remain;
  logic [11:0]             exc_remain;

  assign wr_fire     = aw_got_reg && w_got_reg && !bvalid_reg;
  assign rd_fire     = s_axi_arvalid && !rvalid_reg;
  assign start_cmd   = wr_fire && awaddr_reg == `CTC_ADDR_CTRL && wstrb_reg[0]
                       && wdata_reg[`CTC_CTRL_START];
  assign sleep_cmd   = wr_fire && awaddr_reg == `CTC_ADDR_CTRL && wstrb_reg[0]
                       && wdata_reg[`CTC_CTRL_SLEEP];
  assign result_read = rd_fire && s_axi_araddr == `CTC_ADDR_RESULT;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // register slave
  always_comb
  begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    ctrl_next   = ctrl_reg;
    exc_next    = exc_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `CTC_RESP_OKAY;
      unique case (awaddr_reg)
        `CTC_ADDR_CTRL:
          if (wstrb_reg[0])
          begin
            ctrl_next.continuous = wdata_reg[`CTC_CTRL_CONT];
            ctrl_next.turbo      = wdata_reg[`CTC_CTRL_TURBO];
            ctrl_next.rate       = wdata_reg[`CTC_CTRL_RATE_MSB:`CTC_CTRL_RATE_LSB];
          end
        `CTC_ADDR_EXC:
        begin
          if (wstrb_reg[0])
          begin
            exc_next.code   = wdata_reg[`CTC_EXC_CODE_MSB:`CTC_EXC_CODE_LSB];
            exc_next.route1 = wdata_reg[`CTC_EXC_R1_MSB:`CTC_EXC_R1_LSB];
          end
          if (wstrb_reg[1])
            exc_next.route2 = wdata_reg[`CTC_EXC_R2_MSB:`CTC_EXC_R2_LSB];
        end
        `CTC_ADDR_STATUS, `CTC_ADDR_RESULT: ;
        default: bresp_next = `CTC_RESP_DECERR;
      endcase
    end
    if (rd_fire)
    begin
      rvalid_next = 1'b1;
      rresp_next  = `CTC_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `CTC_ADDR_CTRL:
        begin
          rdata_next[`CTC_CTRL_CONT]  = ctrl_reg.continuous;
          rdata_next[`CTC_CTRL_TURBO] = ctrl_reg.turbo;
          rdata_next[`CTC_CTRL_RATE_MSB:`CTC_CTRL_RATE_LSB] = ctrl_reg.rate;
        end
        `CTC_ADDR_EXC:
        begin
          rdata_next[`CTC_EXC_CODE_MSB:`CTC_EXC_CODE_LSB] = exc_reg.code;
          rdata_next[`CTC_EXC_R1_MSB:`CTC_EXC_R1_LSB]     = exc_reg.route1;
          rdata_next[`CTC_EXC_R2_MSB:`CTC_EXC_R2_LSB]     = exc_reg.route2;
        end
        `CTC_ADDR_STATUS:
        begin
          rdata_next[`CTC_ST_READY]     = !ready_n_reg;
          rdata_next[`CTC_ST_BUSY]      = state_reg != ctc_pkg::CTC_IDLE;
          rdata_next[`CTC_ST_EXC_VALID] = valid_reg;
          rdata_next[`CTC_ST_BIAS]      = bias_reg;
          rdata_next[`CTC_ST_ASLEEP]    = asleep_reg;
        end
        `CTC_ADDR_RESULT: rdata_next[23:0] = result_reg;
        default: rresp_next = `CTC_RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `CTC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= `CTC_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      ctrl_reg   <= '0;
      exc_reg    <= '0;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      ctrl_reg   <= ctrl_next;
      exc_reg    <= exc_next;
    end
  end

  // conversion sequencer, counted in half oscillator periods
  ctc_timer #(.W(17)) conv_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (conv_load),
    .load_val (conv_val),
    .step     (half_tick_reg),
    .remain   (conv_remain),
    .last     (conv_last),
    .done     (conv_done)
  );

  always_comb
  begin
    {half_tick_next, acc_next} = {1'b0, acc_reg}
      + {1'b0, run_reg.turbo ? INC_TURBO : INC_NORM};
    mod_cnt_next  = mod_cnt_reg;
    mod_tick_next = 1'b0;
    if (half_tick_reg && state_reg != ctc_pkg::CTC_IDLE)
    begin
      mod_cnt_next  = mod_cnt_reg + 3'h1;
      mod_tick_next = mod_cnt_reg == `CTC_MOD_DIV_HALF;
    end
    state_next  = state_reg;
    run_next    = run_reg;
    conv_load   = 1'b0;
    conv_val    = 17'h0_0000;
    result_next = result_reg;
    ready_n_next = ready_n_reg;
    asleep_next = asleep_reg;
    if (result_read || (state_reg == ctc_pkg::CTC_CONV && conv_last))
      ready_n_next = 1'b1;
    unique case (state_reg)
      ctc_pkg::CTC_LATENCY:
        if (conv_done)
        begin
          state_next = ctc_pkg::CTC_CONV;
          conv_load  = 1'b1;
          conv_val   = {ctc_time(run_reg.rate, 1'b0, run_reg.turbo), 1'b0};
        end
      ctc_pkg::CTC_CONV:
        if (conv_done)
        begin
          conv_load = 1'b1;
          conv_val  = {ctc_time(run_reg.rate, 1'b0, run_reg.turbo), 1'b0};
        end
      ctc_pkg::CTC_SINGLE:
        if (conv_done)
          state_next = ctc_pkg::CTC_IDLE;
      ctc_pkg::CTC_IDLE: ;
    endcase
    // a sleeping sequencer ignores the timer still running down
    if (conv_done && (state_reg == ctc_pkg::CTC_CONV || state_reg == ctc_pkg::CTC_SINGLE))
    begin
      result_next  = filter_data;
      ready_n_next = 1'b0;
    end
    if (start_cmd)
    begin
      run_next     = ctrl_next;
      asleep_next  = 1'b0;
      mod_cnt_next = 3'h0;
      acc_next     = '0;
      ready_n_next = 1'b1;
      conv_load    = 1'b1;
      if (ctrl_next.continuous)
      begin
        state_next = ctc_pkg::CTC_LATENCY;
        conv_val   = ctrl_next.turbo ? `CTC_LAT_TURBO_X2 : `CTC_LAT_NORM_X2;
      end
      else
      begin
        state_next = ctc_pkg::CTC_SINGLE;
        conv_val   = {ctc_time(ctrl_next.rate, 1'b1, ctrl_next.turbo), 1'b0};
      end
    end
    if (sleep_cmd)
    begin
      asleep_next  = 1'b1;
      state_next   = ctc_pkg::CTC_IDLE;
      ready_n_next = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_reg       <= '0;
      half_tick_reg <= 1'b0;
      mod_cnt_reg   <= 3'h0;
      mod_tick_reg  <= 1'b0;
      state_reg     <= ctc_pkg::CTC_IDLE;
      run_reg       <= '0;
      result_reg    <= 24'h00_0000;
      ready_n_reg   <= 1'b1;
      asleep_reg    <= 1'b0;
    end
    else
    begin
      acc_reg       <= acc_next;
      half_tick_reg <= half_tick_next;
      mod_cnt_reg   <= mod_cnt_next;
      mod_tick_reg  <= mod_tick_next;
      state_reg     <= state_next;
      run_reg       <= run_next;
      result_reg    <= result_next;
      ready_n_reg   <= ready_n_next;
      asleep_reg    <= asleep_next;
    end
  end

  // excitation sources and their start-up wait
  assign exc_load = bias_next && (!bias_reg || exc_next.code != exc_reg.code);

  ctc_timer #(.W(12)) exc_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (exc_load),
    .load_val (EXC_START_CYC),
    .step     (1'b1),
    .remain   (exc_remain),
    .last     (),
    .done     (exc_done)
  );

  always_comb
  begin
    bias_next  = exc_next.code != 3'h0 && !asleep_next;
    drv1_next  = bias_next && exc_next.route1 != 3'h0;
    drv2_next  = bias_next && exc_next.route2 != 3'h0;
    valid_next = bias_next && !exc_load && (valid_reg || exc_done);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bias_reg  <= 1'b0;
      drv1_reg  <= 1'b0;
      drv2_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      bias_reg  <= bias_next;
      drv1_reg  <= drv1_next;
      drv2_reg  <= drv2_next;
      valid_reg <= valid_next;
    end
  end

  assign result_ready_n          = ready_n_reg;
  assign mod_tick                = mod_tick_reg;
  assign exc_bias_en             = bias_reg;
  assign excitation_current_code = exc_reg.code;
  assign first_source_route      = exc_reg.route1;
  assign second_source_route     = exc_reg.route2;
  assign first_source_drive      = drv1_reg;
  assign second_source_drive     = drv2_reg;
  assign exc_current_valid       = valid_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ready_fall_a: assert property ($fell(ready_n_reg) |-> $past(conv_done))
    else $error("ready fell without a completed conversion");
  latency_load_a: assert property (start_cmd && ctrl_next.continuous && !sleep_cmd |=>
    state_reg == ctc_pkg::CTC_LATENCY && conv_remain ==
    (run_reg.turbo ? `CTC_LAT_TURBO_X2 : `CTC_LAT_NORM_X2))
    else $error("wrong start latency loaded");
  latency_once_a: assert property (state_reg == ctc_pkg::CTC_CONV |=>
    state_reg != ctc_pkg::CTC_LATENCY || $past(start_cmd))
    else $error("latency repeated without start");
  single_time_a: assert property (start_cmd && !ctrl_next.continuous |=>
    conv_remain == {ctc_time(run_reg.rate, 1'b1, run_reg.turbo), 1'b0})
    else $error("wrong single-shot time loaded");
  cont_period_a: assert property (conv_done && state_reg == ctc_pkg::CTC_CONV
    && !start_cmd && !sleep_cmd |=> state_reg == ctc_pkg::CTC_CONV
    && conv_remain == {ctc_time(run_reg.rate, 1'b0, run_reg.turbo), 1'b0})
    else $error("continuous period not reloaded");
  sleep_off_a: assert property (sleep_cmd |=> !bias_reg && !drv1_reg && !drv2_reg)
    else $error("sources still on after sleep");
  route_drive_a: assert property (drv1_reg || drv2_reg |-> bias_reg)
    else $error("pin driven without bias");
  startup_wait_a: assert property (exc_load |=> !valid_reg [*8])
    else $error("current flagged valid before start-up");
  mod_quarter_a: assert property (mod_tick_reg |=> !mod_tick_reg [*8])
    else $error("modulator tick too frequent");
  abort_a: assert property (start_cmd && state_reg != ctc_pkg::CTC_IDLE |=>
    ready_n_reg && state_reg != ctc_pkg::CTC_CONV)
    else $error("start did not restart sequence");

  single_done_c: cover property (state_reg == ctc_pkg::CTC_SINGLE && conv_done);
  cont_done_c: cover property (state_reg == ctc_pkg::CTC_CONV && conv_done);
  sleep_c: cover property (sleep_cmd && bias_reg);
  exc_valid_c: cover property ($rose(valid_reg));

endmodule

// ### core/ctc_map.svh
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

// register byte offsets
`define CTC_ADDR_W          8
`define CTC_ADDR_CTRL       8'h00
`define CTC_ADDR_EXC        8'h04
`define CTC_ADDR_STATUS     8'h08
`define CTC_ADDR_RESULT     8'h0C

// control register fields
`define CTC_CTRL_START      0
`define CTC_CTRL_SLEEP      1
`define CTC_CTRL_CONT       2
`define CTC_CTRL_TURBO      3
`define CTC_CTRL_RATE_LSB   4
`define CTC_CTRL_RATE_MSB   6

// excitation register fields
`define CTC_EXC_CODE_LSB    0
`define CTC_EXC_CODE_MSB    2
`define CTC_EXC_R1_LSB      4
`define CTC_EXC_R1_MSB      6
`define CTC_EXC_R2_LSB      8
`define CTC_EXC_R2_MSB      10

// status register fields
`define CTC_ST_READY        0
`define CTC_ST_BUSY         1
`define CTC_ST_EXC_VALID    2
`define CTC_ST_BIAS         3
`define CTC_ST_ASLEEP       4

// bus responses
`define CTC_RESP_OKAY       2'h0
`define CTC_RESP_DECERR     2'h3

// clock and oscillator rates in kHz
`define CTC_CLK_KHZ         10000
`define CTC_OSC_NORM_KHZ    1024
`define CTC_OSC_TURBO_KHZ   2048
`define CTC_ACC_BITS        24
`define CTC_MOD_DIV_HALF    3'h7

// start latency in half oscillator periods: 28.5 and 105 periods
`define CTC_LAT_NORM_X2     17'h0_0039
`define CTC_LAT_TURBO_X2    17'h0_00D2

// excitation start-up time in microseconds
`define CTC_EXC_START_US    200

// continuous periods: 51192 22780 11532 5916 3116 1724 1036
`define CTC_CONT_0          16'hC7F8
`define CTC_CONT_1          16'h58FC
`define CTC_CONT_2          16'h2D0C
`define CTC_CONT_3          16'h171C
`define CTC_CONT_4          16'h0C2C
`define CTC_CONT_5          16'h06BC
`define CTC_CONT_6          16'h040C
// single-shot normal: 51213 22805 11557 5941 3141 1749 1061
`define CTC_SSN_0           16'hC80D
`define CTC_SSN_1           16'h5915
`define CTC_SSN_2           16'h2D25
`define CTC_SSN_3           16'h1735
`define CTC_SSN_4           16'h0C45
`define CTC_SSN_5           16'h06D5
`define CTC_SSN_6           16'h0425
// single-shot turbo: 51217 22809 11561 5945 3145 1753 1065
`define CTC_SST_0           16'hC811
`define CTC_SST_1           16'h5919
`define CTC_SST_2           16'h2D29
`define CTC_SST_3           16'h1739
`define CTC_SST_4           16'h0C49
`define CTC_SST_5           16'h06D9
`define CTC_SST_6           16'h0429

`endif

// ### core/ctc_pkg.sv
package ctc_pkg;

  typedef enum logic [1:0] {
    CTC_IDLE    = 2'b00,
    CTC_LATENCY = 2'b01,
    CTC_CONV    = 2'b10,
    CTC_SINGLE  = 2'b11
  } ctc_state_type;

  typedef struct packed {
    logic [2:0] rate;
    logic       turbo;
    logic       continuous;
  } ctc_ctrl_type;

  typedef struct packed {
    logic [2:0] code;
    logic [2:0] route1;
    logic [2:0] route2;
  } ctc_exc_type;

endpackage

// ### core/ctc_timer.sv
`timescale 1ns/1ns
module ctc_timer #(
  parameter int W = 17
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         step,
  // state
  output logic [W-1:0]      remain,
  output logic              last,
  output logic              done
);

  logic [W-1:0] remain_reg;
  logic [W-1:0] remain_next;

  assign last   = (remain_reg == W'(1));
  assign done   = last && step;
  assign remain = remain_reg;

  always_comb
  begin
    remain_next = remain_reg;
    if (load)
      remain_next = load_val;
    else if (step && remain_reg != '0)
      remain_next = remain_reg - W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      remain_reg <= '0;
    else
      remain_reg <= remain_next;
  end

endmodule

// ### sim/ctc_host_watch.sv
`timescale 1ns/1ns
module ctc_host_watch (
  // clock
  input  wire logic aclk,
  // watched lines
  input  wire logic result_ready_n,
  input  wire logic mod_tick,
  // last gaps in clock cycles
  output int        ready_gap,
  output int        tick_gap
);
  int   ready_cnt = 0;
  int   tick_cnt  = 0;
  logic ready_q   = 1'b1;

  always @(posedge aclk)
  begin
    ready_q   <= result_ready_n;
    ready_cnt <= ready_cnt + 1;
    tick_cnt  <= tick_cnt + 1;
    if (ready_q && !result_ready_n)
    begin
      ready_gap <= ready_cnt;
      ready_cnt <= 1;
    end
    if (mod_tick)
    begin
      tick_gap <= tick_cnt;
      tick_cnt <= 1;
    end
  end
endmodule

// ### sim/test_conversion_timing_and_excitation_control.sv
`timescale 1ns/1ns
`include "ctc_map.svh"
module test_conversion_timing_and_excitation_control;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [23:0] filter_data = 24'h00_0000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat, r;
  logic [2:0]  excitation_current_code, first_source_route, second_source_route;
  logic        result_ready_n, mod_tick, exc_bias_en, exc_current_valid;
  logic        first_source_drive, second_source_drive;
  logic [31:0] seed = 32'h0000_003F;
  logic [7:0]  cv [3] = '{8'h61, 8'h69, 8'h59};
  int          ssn [7] = '{51213, 22805, 11557, 5941, 3141, 1749, 1061};
  int          sst [7] = '{51217, 22809, 11561, 5945, 3145, 1753, 1065};
  int          err_total = 0, checks = 0, ready_gap, tick_gap, n, t;

  always #50 aclk = ~aclk;

  ctc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .filter_data, .result_ready_n, .mod_tick, .exc_bias_en,
    .excitation_current_code, .first_source_route, .second_source_route, .first_source_drive,
    .second_source_drive, .exc_current_valid);
  ctc_host_watch host (.aclk, .result_ready_n, .mod_tick, .ready_gap, .tick_gap);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // half oscillator periods to clock cycles
  function automatic int cyc(input int h, input logic tb);
    return h * 10000 / (tb ? 4096 : 2048);
  endfunction

  task automatic close_out();
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic bad(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic hang();
    bad("no answer in time");
    close_out();
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want)
      bad($sformatf("got %h want %h", got, want));
  endtask

  task automatic near(input int got, input int want, input int tol);
    checks++;
    if (got < want - tol || got > want + tol)
      bad($sformatf("took %0d cycles, want %0d", got, want));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (i == 50)
      hang();
  endtask

  task automatic get(input logic [7:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (i == 50)
      hang();
  endtask

  task automatic wait_rdy(input logic lvl);
    for (n = 0; n < 60000 && result_ready_n !== lvl; n++)
      @(posedge aclk);
    if (n == 60000)
      hang();
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    get(`CTC_ADDR_STATUS);
    cmp(rdat, 32'h0000_0000);
    get(8'h10);
    cmp(rsp, `CTC_RESP_DECERR);
    wr(8'h10, 32'h0000_0000);
    cmp(rsp, `CTC_RESP_DECERR);
    for (t = 0; t < 8; t++)
    begin
      r = rnd();
      wr(`CTC_ADDR_EXC, t);
      wr(`CTC_ADDR_EXC, {21'h00_0000, r[2:0], 1'b0, r[6:4], 1'b0, t[2:0]});
      cmp(excitation_current_code, t[2:0]);
      cmp(first_source_route, r[6:4]);
      cmp(second_source_route, r[2:0]);
      cmp(exc_bias_en, t != 0);
      cmp(first_source_drive, t != 0 && r[6:4] != 0);
      cmp(second_source_drive, t != 0 && r[2:0] != 0);
    end
    wr(`CTC_ADDR_EXC, 32'h0000_0000);
    wr(`CTC_ADDR_EXC, 32'h0000_0003);
    wr(`CTC_ADDR_EXC, 32'h0000_0013);
    cmp(exc_current_valid, 1'b0);
    for (n = 0; n < 3000 && exc_current_valid !== 1'b1; n++)
      @(posedge aclk);
    near(n, 1996, 8);
    for (t = 0; t < 3; t++)
    begin
      r = rnd();
      filter_data <= r[23:0];
      wr(`CTC_ADDR_CTRL, cv[t]);
      wait_rdy(1'b0);
      near(n, cyc(2 * (cv[t][3] ? sst[cv[t][6:4]] : ssn[cv[t][6:4]]), cv[t][3]), 6);
      cmp(exc_bias_en, 1'b1);
      get(`CTC_ADDR_RESULT);
      cmp(rdat, {8'h00, filter_data});
      cmp(result_ready_n, 1'b1);
    end
    wr(`CTC_ADDR_CTRL, 32'h0000_0061);
    repeat (3000) @(posedge aclk);
    wr(`CTC_ADDR_CTRL, 32'h0000_0061);
    wait_rdy(1'b0);
    near(n, cyc(2 * 1061, 1'b0), 6);
    for (t = 0; t < 2; t++)
    begin
      wr(`CTC_ADDR_CTRL, t[0] ? 32'h0000_006D : 32'h0000_0065);
      wait_rdy(1'b0);
      near(n, cyc((t[0] ? 210 : 57) + 2 * 1036, t[0]), 6);
      wait_rdy(1'b1);
      wait_rdy(1'b0);
      @(posedge aclk);
      near(ready_gap, cyc(2 * 1036, t[0]), 4);
      near(tick_gap, cyc(8, t[0]), 2);
    end
    wr(`CTC_ADDR_CTRL, 32'h0000_0002);
    cmp(exc_bias_en, 1'b0);
    cmp(first_source_drive, 1'b0);
    get(`CTC_ADDR_STATUS);
    cmp(rdat, 32'h0000_0010);
    close_out();
  end
endmodule
